// File: hdl/sae_defines.svh
// constants for the storage, alignment and external interrupt exception unit
// assumes a 32-bit classic wishbone slave port and a 125 MHz core clock
`ifndef SAE_DEFINES_SVH
`define SAE_DEFINES_SVH
// vector offsets
`define SAE_VEC_NONE  20'h00000
`define SAE_VEC_DSI   20'h00300
`define SAE_VEC_ISI   20'h00400
`define SAE_VEC_EXT   20'h00500
`define SAE_VEC_ALIGN 20'h00600
// register byte offsets
`define SAE_OFS_CTRL  8'h00
`define SAE_OFS_BKPT  8'h04
`define SAE_OFS_CAUSE 8'h08
`define SAE_OFS_VEC   8'h0c
`define SAE_OFS_STAT  8'h10
// control register bits
`define SAE_CTRL_EE   0
`define SAE_CTRL_LE   1
`define SAE_CTRL_LOCK 2
`define SAE_CTRL_DIS  3
`define SAE_CTRL_BPW  4
`define SAE_CTRL_BPR  5
`define SAE_CTRL_W    6
`define SAE_CTRL_RST  6'h00
// cause register bits
`define SAE_C_DSPROG  0
`define SAE_C_MISS    1
`define SAE_C_PROT    2
`define SAE_C_DSEXT   3
`define SAE_C_DSWT    4
`define SAE_C_BKPT    5
`define SAE_C_SEGMISS 6
`define SAE_C_W       7
`define SAE_BKPT_LSB  3
`endif

// File: hdl/sae_pkg.sv
// types shared by the exception unit and its surroundings
// assumes sae_defines.svh is on the include path
`include "sae_defines.svh"
package sae_pkg;
  typedef enum logic [1:0] {SAE_IDLE = 2'b00, SAE_DRAIN = 2'b01, SAE_TAKE = 2'b11} sae_state_e;
  typedef enum logic [2:0] {
    SAE_K_NONE = 3'h0, SAE_K_ISI = 3'h1, SAE_K_ALIGN = 3'h2, SAE_K_DSI = 3'h3, SAE_K_EXT = 3'h4
  } sae_kind_e;
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        load;
    logic        store;
    logic        fp;
    logic        multi;
    logic        strng;
    logic        resv;
    logic        extctl;
    logic        dcbz;
    logic [1:0]  size_log2;
    logic [31:0] effective_address;
  } sae_acc_s;
  typedef struct packed {
    logic       hit_primary;
    logic       hit_secondary;
    logic       hit_block;
    logic       seg_table_miss;
    logic       segment_direct_store_flag;
    logic       ds_prog_exc;
    logic       supervisor;
    logic       supervisor_key;
    logic       user_key;
    logic [1:0] page_protect_bits;
    logic       write_through;
    logic       cache_inhibited;
  } sae_xlat_s;
endpackage : sae_pkg

// File: hdl/sae_exc.sv
// exception detection and vectoring for data and instruction storage,
// alignment and external interrupt faults, with a wishbone register port
// assumes the access and translation inputs come from logic on sys_clk
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module sae_exc #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire  logic                 sys_clk,
  input  wire  logic                 rst_b,
  input  wire  logic                 ce,
  // wishbone slave
  input  wire  logic                 wb_cyc_i,
  input  wire  logic                 wb_stb_i,
  input  wire  logic                 wb_we_i,
  input  wire  logic [ADDR_W-1:0]    wb_adr_i,
  input  wire  logic [3:0]           wb_sel_i,
  input  wire  logic [31:0]          wb_dat_i,
  output logic       [31:0]          wb_dat_o,
  output logic                       wb_ack_o,
  // pipeline side
  input  wire  sae_pkg::sae_acc_s    acc_i,
  input  wire  sae_pkg::sae_xlat_s   xlat_i,
  input  wire  logic                 inflight_i,
  output logic                       dispatch_stall_o,
  output logic                       exc_valid_o,
  output logic       [19:0]          exc_vector_o,
  output sae_pkg::sae_kind_e         exc_kind_o,
  // external requester
  input  wire  logic                 ext_irq_req
);
  import sae_pkg::*;

  logic [`SAE_CTRL_W-1:0] ctrl_r;
  logic [`SAE_CTRL_W-1:0] ctrl_nxt;
  logic [31:0]            bkpt_r;
  logic [31:0]            bkpt_nxt;
  logic [`SAE_C_W-1:0]    data_fault_cause_reg;
  logic [`SAE_C_W-1:0]    cause_nxt;
  logic [19:0]            vec_r;
  logic [31:0]            rdata_nxt;
  logic                   ack_r;
  logic [31:0]            rdat_r;
  logic                   irq_meta_r;
  logic                   irq_sync_r;
  sae_state_e             state_r;
  sae_state_e             state_nxt;
  logic                   exc_valid_r;
  logic [19:0]            exc_vec_r;
  sae_kind_e              exc_kind_r;
  sae_kind_e              kind_nxt;

  // bus decode
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire       bus_wr    = bus_req & wb_we_i;
  wire [7:0] bus_ofs   = 8'(wb_adr_i);
  wire       sel_ctrl  = bus_ofs == `SAE_OFS_CTRL;
  wire       sel_bkpt  = bus_ofs == `SAE_OFS_BKPT;
  wire       sel_cause = bus_ofs == `SAE_OFS_CAUSE;
  wire       sel_vec   = bus_ofs == `SAE_OFS_VEC;
  wire       sel_stat  = bus_ofs == `SAE_OFS_STAT;
  wire       wr_ctrl   = bus_wr & sel_ctrl & wb_sel_i[0];
  wire       wr_cause  = bus_wr & sel_cause & wb_sel_i[0];

  // control fields
  wire ee_bit      = ctrl_r[`SAE_CTRL_EE];
  wire le_mode     = ctrl_r[`SAE_CTRL_LE];
  wire dc_locked   = ctrl_r[`SAE_CTRL_LOCK];
  wire dc_disabled = ctrl_r[`SAE_CTRL_DIS];
  wire bp_on_write = ctrl_r[`SAE_CTRL_BPW];
  wire bp_on_read  = ctrl_r[`SAE_CTRL_BPR];

  // access classes
  wire        data_acc  = acc_i.valid & ~acc_i.fetch;
  wire        fetch_acc = acc_i.valid & acc_i.fetch;
  wire [31:0] ea        = acc_i.effective_address;
  wire        word_unal = |ea[1:0];
  wire [2:0]  nat_mask  = (3'h1 << acc_i.size_log2) - 3'h1;
  wire        nat_unal  = acc_i.size_log2 == 2'h3 ? |ea[2:0] : |(ea[2:0] & nat_mask);
  wire        word_cls  = acc_i.fp | acc_i.multi | acc_i.resv | acc_i.extctl;

  // alignment conditions
  // word alignment check
  wire al_word = word_cls & word_unal;
  wire al_zatt = acc_i.dcbz & (xlat_i.cache_inhibited | xlat_i.write_through);
  wire al_zcache = acc_i.dcbz & (dc_locked | dc_disabled);
  wire al_le = le_mode & nat_unal;
  wire al_lems = le_mode & (acc_i.multi | acc_i.strng);
  wire align_hit = data_acc & (al_word | al_zatt | al_zcache | al_le | al_lems);

  // translation and protection
  wire seg_ds   = xlat_i.segment_direct_store_flag;
  wire use_key  = xlat_i.supervisor ? xlat_i.supervisor_key : xlat_i.user_key;
  wire [1:0] pp = xlat_i.page_protect_bits;
  wire rd_deny  = use_key & (pp == 2'b00);
  wire wr_deny  = (pp == 2'b11) | (use_key & (pp != 2'b10));
  wire no_xlat  = ~(xlat_i.hit_primary | xlat_i.hit_secondary | xlat_i.hit_block);
  wire bp_match = ea[31:`SAE_BKPT_LSB] == bkpt_r[31:`SAE_BKPT_LSB];

  // data fault cause bits
  logic [`SAE_C_W-1:0] cause_now;
  assign cause_now[`SAE_C_DSPROG] = xlat_i.ds_prog_exc & (acc_i.load | acc_i.store);
  assign cause_now[`SAE_C_MISS] = ~seg_ds & no_xlat;
  assign cause_now[`SAE_C_PROT] = ~seg_ds & ~no_xlat & (acc_i.store ? wr_deny : rd_deny);
  assign cause_now[`SAE_C_DSEXT] = seg_ds & (acc_i.extctl | acc_i.resv);
  assign cause_now[`SAE_C_DSWT] = seg_ds & acc_i.extctl & xlat_i.write_through;
  assign cause_now[`SAE_C_BKPT] = bp_match & ((bp_on_write & acc_i.store) | (bp_on_read & acc_i.load));
  assign cause_now[`SAE_C_SEGMISS] = xlat_i.seg_table_miss;
  wire dsi_hit = data_acc & (|cause_now);

  wire isi_hit = fetch_acc & (no_xlat | seg_ds | rd_deny);

  wire take_isi   = isi_hit;
  wire take_align = ~take_isi & align_hit;
  wire take_dsi   = ~take_isi & ~take_align & dsi_hit;
  wire fault_any  = take_isi | take_align | take_dsi;

  wire irq_live = irq_sync_r & ee_bit;
  wire irq_take = (state_r == SAE_DRAIN) & irq_live & ~inflight_i & ~fault_any;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SAE_IDLE: begin
        if (irq_live) begin
          state_nxt = SAE_DRAIN;
        end
      end
      SAE_DRAIN: begin
        if (!irq_live) begin
          state_nxt = SAE_IDLE;
        end else if (irq_take) begin
          state_nxt = SAE_TAKE;
        end
      end
      SAE_TAKE: state_nxt = SAE_IDLE;
      default:  state_nxt = SAE_IDLE;
    endcase
  end

  always_comb begin
    kind_nxt = SAE_K_NONE;
    if (take_isi) begin
      kind_nxt = SAE_K_ISI;
    end else if (take_align) begin
      kind_nxt = SAE_K_ALIGN;
    end else if (take_dsi) begin
      kind_nxt = SAE_K_DSI;
    end else if (irq_take) begin
      kind_nxt = SAE_K_EXT;
    end
  end

  wire [19:0] vec_nxt = kind_nxt == SAE_K_ISI   ? `SAE_VEC_ISI   :
                        kind_nxt == SAE_K_ALIGN ? `SAE_VEC_ALIGN :
                        kind_nxt == SAE_K_DSI   ? `SAE_VEC_DSI   :
                        kind_nxt == SAE_K_EXT   ? `SAE_VEC_EXT   : `SAE_VEC_NONE;
  wire take_any = kind_nxt != SAE_K_NONE;

  // enable bit cleared by any taken exception
  always_comb begin
    ctrl_nxt = wr_ctrl ? wb_dat_i[`SAE_CTRL_W-1:0] : ctrl_r;
    if (take_any) begin
      ctrl_nxt[`SAE_CTRL_EE] = 1'b0;
    end
  end

  always_comb begin
    cause_nxt = wr_cause ? (data_fault_cause_reg & ~wb_dat_i[`SAE_C_W-1:0]) : data_fault_cause_reg;
    if (take_dsi) begin
      cause_nxt = cause_now;
    end
  end

  genvar gb;
  for (gb = 0; gb < 4; gb++) begin : g_bkpt
    assign bkpt_nxt[gb*8 +: 8] = (bus_wr & sel_bkpt & wb_sel_i[gb]) ? wb_dat_i[gb*8 +: 8] : bkpt_r[gb*8 +: 8];
  end

  assign rdata_nxt = sel_ctrl  ? {{(32-`SAE_CTRL_W){1'b0}}, ctrl_r} :
                     sel_bkpt  ? bkpt_r :
                     sel_cause ? {{(32-`SAE_C_W){1'b0}}, data_fault_cause_reg} :
                     sel_vec   ? {12'h000, vec_r} :
                     sel_stat  ? {28'h0000000, state_r, dispatch_stall_o, irq_sync_r} : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
    end else if (ce) begin
      irq_meta_r <= ext_irq_req;
      irq_sync_r <= irq_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else if (ce) begin
      ack_r  <= bus_req;
      rdat_r <= bus_req ? rdata_nxt : rdat_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r               <= `SAE_CTRL_RST;
      bkpt_r               <= 32'h00000000;
      data_fault_cause_reg <= 7'h00;
    end else if (ce) begin
      ctrl_r               <= ctrl_nxt;
      bkpt_r               <= bkpt_nxt;
      data_fault_cause_reg <= cause_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= SAE_IDLE;
      exc_valid_r <= 1'b0;
      exc_vec_r   <= `SAE_VEC_NONE;
      exc_kind_r  <= SAE_K_NONE;
      vec_r       <= `SAE_VEC_NONE;
    end else if (ce) begin
      state_r     <= state_nxt;
      exc_valid_r <= take_any;
      exc_vec_r   <= vec_nxt;
      exc_kind_r  <= kind_nxt;
      vec_r       <= take_any ? vec_nxt : vec_r;
    end
  end

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = rdat_r;
  assign dispatch_stall_o = state_r != SAE_IDLE;
  assign exc_valid_o      = exc_valid_r;
  assign exc_vector_o     = exc_vec_r;
  assign exc_kind_o       = exc_kind_r;

  // checks
  dsi_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && take_dsi |=> exc_valid_o && exc_vector_o == `SAE_VEC_DSI && data_fault_cause_reg == $past(cause_now))
    else $error("data fault vector or causes wrong");
  isi_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && fetch_acc && seg_ds |=> exc_kind_o == SAE_K_ISI && exc_vector_o == `SAE_VEC_ISI)
    else $error("fetch fault not taken");
  isi_xlat_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && fetch_acc && no_xlat |=> exc_kind_o == SAE_K_ISI && exc_vector_o == `SAE_VEC_ISI)
    else $error("untranslated fetch not faulted");
  isi_prot_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && fetch_acc && rd_deny |=> exc_kind_o == SAE_K_ISI)
    else $error("protected fetch not faulted");
  zero_attr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && data_acc && acc_i.dcbz && xlat_i.cache_inhibited |=> exc_vector_o == `SAE_VEC_ALIGN)
    else $error("block-zero to inhibited page not faulted");
  zero_cache_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && data_acc && acc_i.dcbz && (dc_locked || dc_disabled) |=> exc_vector_o == `SAE_VEC_ALIGN)
    else $error("block-zero with cache off not faulted");
  le_natural_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && data_acc && le_mode && acc_i.size_log2 == 2'h1 && ea[0] |=> exc_vector_o == `SAE_VEC_ALIGN)
    else $error("little-endian misaligned access not faulted");
  le_multi_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && data_acc && le_mode && acc_i.multi |=> exc_vector_o == `SAE_VEC_ALIGN)
    else $error("little-endian multiple op not faulted");
  segmiss_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && take_dsi |=> data_fault_cause_reg[`SAE_C_SEGMISS] == $past(xlat_i.seg_table_miss))
    else $error("segment miss cause bit wrong");
  ce_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ce |=> $stable(exc_valid_o) && $stable(state_r) && $stable(wb_ack_o))
    else $error("state moved while enable low");
  align_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && data_acc && word_cls && word_unal && !fetch_acc |=> exc_vector_o == `SAE_VEC_ALIGN)
    else $error("alignment fault not taken");
  miss_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && take_dsi && !seg_ds |=> data_fault_cause_reg[`SAE_C_MISS] == $past(no_xlat))
    else $error("miss cause bit wrong");
  irq_order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && fault_any |=> exc_kind_o != SAE_K_EXT)
    else $error("interrupt taken ahead of fault");
  irq_drain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && exc_kind_o == SAE_K_EXT |-> $past(dispatch_stall_o) && !$past(inflight_i))
    else $error("interrupt taken before drain");
  irq_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && exc_kind_o == SAE_K_EXT |-> $past(ee_bit) && !ee_bit)
    else $error("interrupt taken while disabled");
  irq_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && irq_take |=> exc_valid_o && exc_vector_o == `SAE_VEC_EXT ##1 !dispatch_stall_o || !ce)
    else $error("interrupt vector wrong");
  one_exc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $onehot0({take_isi, take_align, take_dsi, irq_take}))
    else $error("more than one exception chosen");
  bus_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ce && bus_req |=> wb_ack_o ##1 !wb_ack_o || !ce)
    else $error("bus ack not single cycle");

  take_dsi_c:  cover property (@(posedge sys_clk) disable iff (!rst_b) ce && take_dsi && $countones(cause_now) > 1);
  take_irq_c:  cover property (@(posedge sys_clk) disable iff (!rst_b) ce && irq_take);
  irq_wait_c:  cover property (@(posedge sys_clk) disable iff (!rst_b) state_r == SAE_DRAIN && fault_any);
  take_algn_c: cover property (@(posedge sys_clk) disable iff (!rst_b) ce && take_align && al_lems);
  take_isi_c:  cover property (@(posedge sys_clk) disable iff (!rst_b) ce && take_isi && rd_deny);
endmodule : sae_exc

// File: testbench/sae_irq_src.sv
// model of the external interrupt requester on the request pin
// assumes the unit's taken pulse and kind are on sys_clk
`timescale 1ns/1ps
module sae_irq_src (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // bench command and unit outputs
  input  wire logic               raise,
  input  wire logic               exc_valid_o,
  input  wire sae_pkg::sae_kind_e exc_kind_o,
  // request pin
  output logic                    ext_irq_req
);
  import sae_pkg::*;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      ext_irq_req <= 1'b0;
    else if (raise)
      ext_irq_req <= 1'b1;
    else if (exc_valid_o && exc_kind_o == SAE_K_EXT)
      ext_irq_req <= 1'b0;
  end
endmodule : sae_irq_src

// File: testbench/tb_sae_exc.sv
// bench for the exception unit: bus, access and interrupt scenarios
// assumes sae_defines.svh on the include path and the requester model
`timescale 1ns/1ps
`include "sae_defines.svh"
module tb_sae_exc;
  import sae_pkg::*;
  localparam logic [8:0]  F_FET = 9'h100, F_LD = 9'h080, F_ST = 9'h040, F_FP = 9'h020;
  localparam logic [8:0]  F_MUL = 9'h010, F_RSV = 9'h004, F_EXT = 9'h002, F_DCBZ = 9'h001;
  localparam logic [19:0] VD = `SAE_VEC_DSI, VI = `SAE_VEC_ISI, VA = `SAE_VEC_ALIGN;
  localparam sae_acc_s    LDW = {1'b1, F_LD, 2'd2, 32'h100};
  localparam sae_xlat_s   XOK = '{hit_primary: 1'b1, page_protect_bits: 2'b10, default: '0};
  localparam sae_xlat_s   XRD = '{hit_block: 1'b1, user_key: 1'b1, default: '0};
  localparam sae_xlat_s   XWR = '{hit_primary: 1'b1, page_protect_bits: 2'b11, default: '0};
  localparam sae_xlat_s   XDS = '{segment_direct_store_flag: 1'b1, ds_prog_exc: 1'b1, write_through: 1'b1,
                                  default: '0};
  localparam sae_xlat_s   XDF = XOK | 13'h0100;
  localparam sae_xlat_s   XSG = XOK | 13'h0200;
  localparam sae_xlat_s   XWT = XOK | 13'h0002;
  localparam sae_xlat_s   XCI = XOK | 13'h0001;
  // clock, reset, bus
  logic        sys_clk, rst_b, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  // pipeline and requester
  sae_acc_s    acc_i;
  sae_xlat_s   xlat_i;
  logic        inflight_i, dispatch_stall_o, exc_valid_o, ext_irq_req, raise;
  logic [19:0] exc_vector_o;
  sae_kind_e   exc_kind_o;
  int          mismatches, checks_done;
  sae_exc u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_i(acc_i), .xlat_i(xlat_i), .inflight_i(inflight_i),
    .dispatch_stall_o(dispatch_stall_o), .exc_valid_o(exc_valid_o), .exc_vector_o(exc_vector_o),
    .exc_kind_o(exc_kind_o), .ext_irq_req(ext_irq_req));
  sae_irq_src u_src (.sys_clk(sys_clk), .rst_b(rst_b), .raise(raise), .exc_valid_o(exc_valid_o),
    .exc_kind_o(exc_kind_o), .ext_irq_req(ext_irq_req));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(wb_ack_o, 1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  function automatic sae_acc_s mk(input logic [8:0] f, input logic [1:0] s, input logic [31:0] ea);
    return {1'b1, f, s, ea};
  endfunction : mk
  task automatic acc(input sae_acc_s a, input sae_xlat_s x, input sae_kind_e k, input logic [19:0] v,
                     input logic [7:0] c);
    @(posedge sys_clk);
    acc_i  <= a;
    xlat_i <= x;
    @(posedge sys_clk);
    acc_i  <= '0;
    #1;
    chk(exc_valid_o, k != SAE_K_NONE);
    chk(exc_kind_o, k);
    chk(exc_vector_o, v);
    if (k == SAE_K_DSI)
      rd(`SAE_OFS_CAUSE, c);
  endtask : acc
  task automatic t_reset();
    #1;
    chk({exc_valid_o, dispatch_stall_o}, 0);
    rd(`SAE_OFS_CTRL, 0);
    rd(`SAE_OFS_CAUSE, 0);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 0);
    wr(`SAE_OFS_VEC, 32'hffff_ffff);
    rd(`SAE_OFS_VEC, 0);
  endtask : t_reset
  task automatic t_dsi();
    acc(LDW, '0, SAE_K_DSI, VD, 8'h02);
    acc(LDW, XOK, SAE_K_NONE, 20'h0, 8'h0);
    acc(LDW, XRD, SAE_K_DSI, VD, 8'h04);
    acc(mk(F_ST, 2, 32'h100), XWR, SAE_K_DSI, VD, 8'h04);
    acc(mk(F_EXT | F_LD, 2, 32'h200), XDS, SAE_K_DSI, VD, 8'h19);
    acc(mk(F_RSV | F_LD, 2, 32'h200), XDF, SAE_K_DSI, VD, 8'h08);
    acc(LDW, XSG, SAE_K_DSI, VD, 8'h40);
    wr(`SAE_OFS_CAUSE, 32'hff);
    rd(`SAE_OFS_CAUSE, 0);
  endtask : t_dsi
  task automatic t_bkpt();
    wr(`SAE_OFS_BKPT, 32'h1000);
    for (int m = 1; m < 4; m++) begin
      wr(`SAE_OFS_CTRL, m << 4);
      acc(mk(m == 1 ? F_ST : F_LD, 2, 32'h1004), XOK, SAE_K_DSI, VD, 8'h20);
    end
    acc(mk(F_LD, 2, 32'h1008), XOK, SAE_K_NONE, 20'h0, 8'h0);
    wr(`SAE_OFS_CTRL, 0);
  endtask : t_bkpt
  task automatic t_isi();
    acc(mk(F_FET, 2, 32'h400), '0, SAE_K_ISI, VI, 8'h0);
    acc(mk(F_FET, 2, 32'h400), XDF, SAE_K_ISI, VI, 8'h0);
    acc(mk(F_FET, 2, 32'h400), XRD, SAE_K_ISI, VI, 8'h0);
  endtask : t_isi
  task automatic t_align();
    logic [8:0] cls [4] = '{F_FP, F_MUL, F_RSV, F_EXT};
    foreach (cls[i]) acc(mk(cls[i] | F_LD, 2, 32'h102), XOK, SAE_K_ALIGN, VA, 8'h0);
    acc(mk(F_DCBZ | F_ST, 2, 32'h100), XCI, SAE_K_ALIGN, VA, 8'h0);
    acc(mk(F_DCBZ | F_ST, 2, 32'h100), XWT, SAE_K_ALIGN, VA, 8'h0);
    acc(mk(F_DCBZ | F_ST, 2, 32'h100), XOK, SAE_K_NONE, 20'h0, 8'h0);
    for (int m = 4; m < 9; m += 4) begin
      wr(`SAE_OFS_CTRL, m);
      acc(mk(F_DCBZ | F_ST, 2, 32'h100), XOK, SAE_K_ALIGN, VA, 8'h0);
    end
    wr(`SAE_OFS_CTRL, 2);
    acc(mk(F_LD, 1, 32'h101), XOK, SAE_K_ALIGN, VA, 8'h0);
    acc(mk(F_LD, 1, 32'h102), XOK, SAE_K_NONE, 20'h0, 8'h0);
    acc(mk(F_MUL | F_LD, 2, 32'h100), XOK, SAE_K_ALIGN, VA, 8'h0);
    wr(`SAE_OFS_CTRL, 0);
    acc(mk(F_FP | F_LD, 2, 32'h102), '0, SAE_K_ALIGN, VA, 8'h0);
  endtask : t_align
  task automatic t_ce();
    @(posedge sys_clk);
    ce     <= 1'b0;
    acc_i  <= LDW;
    xlat_i <= '0;
    repeat (2) @(posedge sys_clk);
    acc_i  <= '0;
    #1;
    chk(exc_valid_o, 0);
    @(posedge sys_clk);
    ce <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(exc_valid_o, 0);
  endtask : t_ce
  task automatic t_irq();
    int n;
    @(posedge sys_clk);
    raise <= 1'b1;
    @(posedge sys_clk);
    raise <= 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      chk({dispatch_stall_o, exc_valid_o}, 0);
    end
    @(posedge sys_clk);
    inflight_i <= 1'b1;
    wr(`SAE_OFS_CTRL, 1);
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      chk({dispatch_stall_o, exc_valid_o}, 2'b10);
    end
    acc(LDW, '0, SAE_K_DSI, VD, 8'h02);
    #1;
    chk(dispatch_stall_o, 0);
    wr(`SAE_OFS_CTRL, 1);
    repeat (3) @(posedge sys_clk);
    inflight_i <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (exc_valid_o !== 1'b1 && n < 10);
    chk(exc_vector_o, `SAE_VEC_EXT);
    chk(exc_kind_o, SAE_K_EXT);
    @(posedge sys_clk);
    #1;
    chk({dispatch_stall_o, ext_irq_req}, 0);
    rd(`SAE_OFS_VEC, 32'h500);
  endtask : t_irq
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, inflight_i, raise} = '0;
    {wb_adr_i, wb_dat_i, acc_i, xlat_i} = '0;
    wb_sel_i = 4'hf;
    ce = 1'b1;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_dsi();
    t_bkpt();
    t_isi();
    t_align();
    t_ce();
    t_irq();
    end_sim();
  end
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule : tb_sae_exc
